// >>> design/tpif_top.sv
// shared prescaler, clock select for five timers, timer5 mask and flags
// assumes an APB master, a timer5 counter core on clk_sys, asynchronous pins
`timescale 1ns/1ns

// Behaviour
// - enabled flag plus global enable raises interrupt
// - match flag set on next timer tick
// - forced compare never sets match flag
// - vector execution clears its flag
// - writing one clears flag, zero keeps
// - overflow flag source follows waveform mode
// - capture enable and flag do nothing
// - reserved bits read zero, ignore writes
// - five timers share prescaler, own selects
// - code one every clock, four taps
// - prescaler free-runs, first count 1..N+1
// - prescaler reset restarts all timers' taps
// - pin latched high phase, then registered
// - one pulse per rise(7) or fall(6)
// - pin edge to count 2.5..3.5 clocks
// - external edges bypass prescaler
// - prescaler reset self-clears unless hold set
module tpif_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tpif_pkg::ADDR_W-1:0] paddr,
   input wire logic [tpif_pkg::DATA_W-1:0] pwdata,
   output logic [tpif_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // external count pins, one per timer
   input wire logic [tpif_pkg::NUM_TIMERS-1:0] extCountPin,
   // timer count clock enables, one per timer
   output logic [tpif_pkg::NUM_TIMERS-1:0] timerCountClock,
   // timer5 counter core events
   input wire logic cmpMatchA,
   input wire logic cmpMatchB,
   input wire logic cmpMatchC,
   input wire logic counterWrap,
   input wire logic altOverflowEvent,
   input wire logic [tpif_pkg::WGM_W-1:0] waveformModeSelect,
   // interrupt controller
   input wire logic globalIrqEnable,
   input wire logic vecAckCmpA,
   input wire logic vecAckCmpB,
   input wire logic vecAckCmpC,
   input wire logic vecAckOverflow,
   output logic irqCmpA,
   output logic irqCmpB,
   output logic irqCmpC,
   output logic irqOverflow
);
   import tpif_pkg::*;

   typedef struct packed {
      logic [NUM_EVT-1:0] flags;
      logic [NUM_EVT-1:0] evtEn;
      logic capEn;
      logic [CLKSEL_W-1:0] clkSel;
      logic psr;
      logic timer_sync_hold;
      logic [DATA_W-1:0] rdata;
      logic slvErr;
   } tpif_top_s;

   tpif_top_s state_r;
   tpif_top_s state_nxt;

   logic [NUM_TAPS-1:0] taps;
   logic [NUM_TIMERS-1:0] riseTick;
   logic [NUM_TIMERS-1:0] fallTick;
   logic tick5;
   logic setupPh;
   logic wrAcc;
   logic hitFlags;
   logic hitMask;
   logic hitGctrl;
   logic hitClkSel;
   logic ovfSrcNormal;
   logic [NUM_EVT-1:0] evtSet;
   logic [NUM_EVT-1:0] evtClr;
   logic [NUM_EVT-1:0] vecAck;
   logic [7:0] flagsRead;
   logic [7:0] maskRead;

   // pick one count enable from the select code
   function automatic logic selTick(input logic [CS_W-1:0] cs,
                                    input logic [NUM_TAPS-1:0] tp,
                                    input logic rise,
                                    input logic fall);
      logic t;
      t = 1'b0;
      case (cs)
         CS_STOP: t = 1'b0;
         CS_DIV1: t = 1'b1;
         CS_DIV8: t = tp[0];
         CS_DIV64: t = tp[1];
         CS_DIV256: t = tp[2];
         CS_DIV1024: t = tp[3];
         CS_EXT_FALL: t = fall;
         CS_EXT_RISE: t = rise;
         default: t = 1'b0;
      endcase
      return t;
   endfunction

   function automatic logic [CS_W-1:0] csOf(input logic [CLKSEL_W-1:0] all,
                                            input int idx);
      return all[idx*CS_W +: CS_W];
   endfunction

   // shared prescaler, reset by the control bit
   tpif_prescaler u_presc (
      .clk_sys(clk_sys),
      .rst(rst),
      .prescClear(state_r.psr),
      .taps(taps)
   );

   // per-timer pin sampling and select
   genvar gi;
   generate
      for (gi = 0; gi < NUM_TIMERS; gi++) begin : g_timer
         tpif_ext_sync u_sync (
            .clk_sys(clk_sys),
            .rst(rst),
            .extCountPin(extCountPin[gi]),
            .riseTick(riseTick[gi]),
            .fallTick(fallTick[gi])
         );
         // same taps for all, own select each
         assign timerCountClock[gi] = selTick(csOf(state_r.clkSel, gi), taps,
                                              riseTick[gi], fallTick[gi]);
      end
   endgenerate

   assign tick5 = timerCountClock[NUM_TIMERS-1];

   // bus decode
   assign setupPh = psel & ~penable;
   assign wrAcc = psel & penable & pwrite;
   assign hitFlags = (paddr == ADDR_FLAGS);
   assign hitMask = (paddr == ADDR_MASK);
   assign hitGctrl = (paddr == ADDR_GCTRL);
   assign hitClkSel = (paddr == ADDR_CLKSEL);

   // flag sources
   assign ovfSrcNormal = (waveformModeSelect == WGM_NORMAL) ||
                         (waveformModeSelect == WGM_CTC_CMP) ||
                         (waveformModeSelect == WGM_CTC_CAP);

   always_comb begin
      evtSet = '0;
      // only true matches set these; forced strobes are not inputs here
      evtSet[BIT_CMPA] = tick5 & cmpMatchA;
      evtSet[BIT_CMPB] = tick5 & cmpMatchB;
      evtSet[BIT_CMPC] = tick5 & cmpMatchC;
      evtSet[BIT_OVF] = tick5 & (ovfSrcNormal ? counterWrap : altOverflowEvent);
   end

   always_comb begin
      vecAck = '0;
      vecAck[BIT_CMPA] = vecAckCmpA;
      vecAck[BIT_CMPB] = vecAckCmpB;
      vecAck[BIT_CMPC] = vecAckCmpC;
      vecAck[BIT_OVF] = vecAckOverflow;
   end

   assign evtClr = vecAck | ((wrAcc && hitFlags) ? pwdata[NUM_EVT-1:0] : '0);

   // read images; capture flag never set, reserved bits zero
   always_comb begin
      flagsRead = REG_RESET;
      flagsRead[NUM_EVT-1:0] = state_r.flags;
      maskRead = REG_RESET;
      maskRead[NUM_EVT-1:0] = state_r.evtEn;
      maskRead[BIT_CAP] = state_r.capEn;
   end

   always_comb begin
      state_nxt = state_r;
      // set wins over any clear in the same cycle
      state_nxt.flags = (state_r.flags & ~evtClr) | evtSet;
      if (wrAcc && hitMask) begin
         state_nxt.evtEn = pwdata[NUM_EVT-1:0];
         state_nxt.capEn = pwdata[BIT_CAP];
      end
      if (wrAcc && hitClkSel) begin
         state_nxt.clkSel = pwdata[CLKSEL_W-1:0];
      end
      if (wrAcc && hitGctrl) begin
         state_nxt.timer_sync_hold = pwdata[BIT_TSM];
         state_nxt.psr = pwdata[BIT_PSR];
      end else if (!state_r.timer_sync_hold) begin
         state_nxt.psr = 1'b0;
      end
      if (setupPh) begin
         state_nxt.rdata = '0;
         state_nxt.slvErr = ~(hitFlags | hitMask | hitGctrl | hitClkSel);
         if (hitFlags) begin
            state_nxt.rdata[7:0] = flagsRead;
         end else if (hitMask) begin
            state_nxt.rdata[7:0] = maskRead;
         end else if (hitGctrl) begin
            state_nxt.rdata[BIT_TSM] = state_r.timer_sync_hold;
            state_nxt.rdata[BIT_PSR] = state_r.psr;
         end else if (hitClkSel) begin
            state_nxt.rdata[CLKSEL_W-1:0] = state_r.clkSel;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign pready = psel & penable;
   assign prdata = state_r.rdata;
   assign pslverr = state_r.slvErr & psel & penable;

   // capture enable is deliberately not part of any request
   assign irqCmpA = globalIrqEnable & state_r.evtEn[BIT_CMPA] & state_r.flags[BIT_CMPA];
   assign irqCmpB = globalIrqEnable & state_r.evtEn[BIT_CMPB] & state_r.flags[BIT_CMPB];
   assign irqCmpC = globalIrqEnable & state_r.evtEn[BIT_CMPC] & state_r.flags[BIT_CMPC];
   assign irqOverflow = globalIrqEnable & state_r.evtEn[BIT_OVF] & state_r.flags[BIT_OVF];

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   a_irq_gate: assert property (
      !irqCmpB || (globalIrqEnable && state_r.evtEn[BIT_CMPB] && state_r.flags[BIT_CMPB]))
      else $error("compare b request not gated by enables");

   a_cmp_flag_set: assert property (
      (tick5 && cmpMatchA) |=> state_r.flags[BIT_CMPA])
      else $error("compare a flag missed after match tick");

   a_flag_no_source: assert property (
      (!state_r.flags[BIT_CMPC] && !(tick5 && cmpMatchC)) |=> !state_r.flags[BIT_CMPC])
      else $error("compare c flag set without a match");

   a_vector_clear: assert property (
      (vecAckCmpB && !(tick5 && cmpMatchB)) |=> !state_r.flags[BIT_CMPB] && !irqCmpB)
      else $error("vector execution did not clear compare b");

   a_write_one_clear: assert property (
      (wrAcc && hitFlags && pwdata[BIT_OVF] && !evtSet[BIT_OVF]) |=> !state_r.flags[BIT_OVF])
      else $error("write one did not clear overflow flag");

   a_ovf_mode: assert property (
      (tick5 && counterWrap && waveformModeSelect == WGM_NORMAL) |=>
      state_r.flags[BIT_OVF] ##0 (irqOverflow == (globalIrqEnable && state_r.evtEn[BIT_OVF])))
      else $error("overflow in normal mode did not set flag");

   a_reserved_zero: assert property (
      (setupPh && (hitFlags || hitMask)) |=> (prdata[7:6] == 2'b00) && !prdata[4] &&
      (!$past(hitFlags) || !prdata[BIT_CAP]))
      else $error("reserved or capture bit read nonzero");

   a_div1_every: assert property (
      (csOf(state_r.clkSel, NUM_TIMERS-1) == CS_DIV1)[*3] |-> tick5)
      else $error("code one did not count every clock");

   a_stop_silent: assert property (
      (csOf(state_r.clkSel, 0) == CS_STOP) |-> !timerCountClock[0])
      else $error("stopped timer received a count");

   a_psr_autoclear: assert property (
      (state_r.psr && !state_r.timer_sync_hold && !(wrAcc && hitGctrl)) |=> !state_r.psr ##1 !state_r.psr)
      else $error("prescaler reset did not self clear");

   a_psr_hold: assert property (
      (state_r.psr && state_r.timer_sync_hold && !(wrAcc && hitGctrl)) |=> state_r.psr && taps == '0)
      else $error("prescaler reset not held in sync mode");

   a_ext_bypass: assert property (
      (csOf(state_r.clkSel, 1) == CS_EXT_RISE) |-> (timerCountClock[1] == riseTick[1]))
      else $error("external rise not passed straight through");

   a_irq_off: assert property (
      !globalIrqEnable |-> (!irqCmpA && !irqCmpC && !irqOverflow))
      else $error("request raised with global enable off");

   a_irq_masked: assert property (
      !state_r.evtEn[BIT_CMPC] |-> !irqCmpC)
      else $error("compare c request raised while masked");

   a_irq_raise: assert property (
      (globalIrqEnable && state_r.evtEn[BIT_CMPA] && state_r.flags[BIT_CMPA]) |-> irqCmpA)
      else $error("enabled compare a flag raised no request");

   a_cmp_b_set: assert property (
      (tick5 && cmpMatchB) |=> state_r.flags[BIT_CMPB])
      else $error("compare b flag missed after match tick");

   a_cmp_c_set: assert property (
      (tick5 && cmpMatchC) |=> state_r.flags[BIT_CMPC])
      else $error("compare c flag missed after match tick");

   a_no_tick_hold: assert property (
      (!tick5 && !state_r.flags[BIT_CMPB]) |=> !state_r.flags[BIT_CMPB])
      else $error("compare b flag set without a timer tick");

   a_ovf_vector: assert property (
      (vecAckOverflow && !evtSet[BIT_OVF]) |=> !state_r.flags[BIT_OVF])
      else $error("vector execution did not clear overflow");

   a_write_zero_keep: assert property (
      (wrAcc && hitFlags && !pwdata[BIT_CMPA] && !vecAckCmpA && state_r.flags[BIT_CMPA])
      |=> state_r.flags[BIT_CMPA])
      else $error("write of zero cleared compare a flag");

   a_ovf_alt: assert property (
      (tick5 && altOverflowEvent && !ovfSrcNormal) |=> state_r.flags[BIT_OVF])
      else $error("overflow in other mode did not set flag");

   a_tap_nest: assert property (
      taps[3] |-> (taps[2] && taps[1] && taps[0]))
      else $error("slow tap fired without the faster taps");

   a_psr_taps_off: assert property (
      state_r.psr |-> (taps == '0))
      else $error("tap fired while prescaler held in reset");

   a_edge_excl: assert property (
      !(riseTick[0] && fallTick[0]))
      else $error("rise and fall pulse in one cycle");

   a_ext_fall: assert property (
      (csOf(state_r.clkSel, 2) == CS_EXT_FALL) |-> (timerCountClock[2] == fallTick[2]))
      else $error("external fall not passed straight through");

   a_div8_tap: assert property (
      (csOf(state_r.clkSel, 1) == CS_DIV8) |-> (timerCountClock[1] == taps[0]))
      else $error("code two did not follow the divide by 8 tap");
endmodule

// >>> design/tpif_pkg.sv
// constants shared by the timer prescaler and timer5 flag logic
// assumes an APB master with 32-bit data and a 100 MHz system clock
package tpif_pkg;
   // bus
   localparam int ADDR_W = 10;
   localparam int DATA_W = 32;
   localparam logic [7:0] IDX_FLAGS = 8'h3A;
   localparam logic [7:0] IDX_MASK = 8'h73;
   localparam logic [7:0] IDX_GCTRL = 8'h43;
   localparam logic [7:0] IDX_CLKSEL = 8'h80;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_MASK = {IDX_MASK, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_GCTRL = {IDX_GCTRL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CLKSEL = {IDX_CLKSEL, 2'b00};
   // flag and mask fields
   localparam int BIT_OVF = 0;
   localparam int BIT_CMPA = 1;
   localparam int BIT_CMPB = 2;
   localparam int BIT_CMPC = 3;
   localparam int BIT_CAP = 5;
   localparam int NUM_EVT = 4;
   localparam logic [7:0] REG_RESET = 8'h00;
   // global timer control fields
   localparam int BIT_PSR = 0;
   localparam int BIT_TSM = 7;
   // clock select
   localparam int NUM_TIMERS = 5;
   localparam int CS_W = 3;
   localparam int CLKSEL_W = NUM_TIMERS * CS_W;
   localparam logic [CS_W-1:0] CS_STOP = 3'h0;
   localparam logic [CS_W-1:0] CS_DIV1 = 3'h1;
   localparam logic [CS_W-1:0] CS_DIV8 = 3'h2;
   localparam logic [CS_W-1:0] CS_DIV64 = 3'h3;
   localparam logic [CS_W-1:0] CS_DIV256 = 3'h4;
   localparam logic [CS_W-1:0] CS_DIV1024 = 3'h5;
   localparam logic [CS_W-1:0] CS_EXT_FALL = 3'h6;
   localparam logic [CS_W-1:0] CS_EXT_RISE = 3'h7;
   // prescaler taps, as widths of the all-ones low field
   localparam int PRESC_W = 10;
   localparam int TAP8_W = 3;
   localparam int TAP64_W = 6;
   localparam int TAP256_W = 8;
   localparam int TAP1024_W = 10;
   localparam int NUM_TAPS = 4;
   // waveform modes that take overflow as the flag source
   localparam int WGM_W = 4;
   localparam logic [WGM_W-1:0] WGM_NORMAL = 4'h0;
   localparam logic [WGM_W-1:0] WGM_CTC_CMP = 4'h4;
   localparam logic [WGM_W-1:0] WGM_CTC_CAP = 4'hC;
endpackage

// >>> design/tpif_prescaler.sv
// free-running 10-bit prescaler with divide-by 8/64/256/1024 tap pulses
// assumes clear comes from a register on clk_sys
`timescale 1ns/1ns
module tpif_prescaler (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // control
   input wire logic prescClear,
   // tap pulses, one cycle each
   output logic [tpif_pkg::NUM_TAPS-1:0] taps
);
   import tpif_pkg::*;

   typedef struct packed {
      logic [PRESC_W-1:0] cnt;
   } tpif_presc_s;

   tpif_presc_s state_r;
   tpif_presc_s state_nxt;

   function automatic logic tapHit(input logic [PRESC_W-1:0] c, input int w);
      logic [PRESC_W-1:0] m;
      m = ~({PRESC_W{1'b1}} << w);
      return (c & m) == m;
   endfunction

   always_comb begin
      state_nxt = state_r;
      state_nxt.cnt = prescClear ? '0 : state_r.cnt + 1'b1;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // no tap fires while clear is held, its first cycle included
   assign taps = {tapHit(state_r.cnt, TAP1024_W), tapHit(state_r.cnt, TAP256_W),
                  tapHit(state_r.cnt, TAP64_W), tapHit(state_r.cnt, TAP8_W)} &
                 ~{NUM_TAPS{prescClear}};
endmodule

// >>> design/tpif_ext_sync.sv
// external count pin sampler and edge detector
// assumes the pin is asynchronous to clk_sys and slower than clk_sys/2
`timescale 1ns/1ns
module tpif_ext_sync (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // pin
   input wire logic extCountPin,
   // edge pulses, one cycle each
   output logic riseTick,
   output logic fallTick
);
   typedef struct packed {
      logic syncQ;
      logic prevQ;
      logic rise;
      logic fall;
   } tpif_sync_s;

   tpif_sync_s state_r;
   tpif_sync_s state_nxt;
   logic latchQ_r;

   // latch open in the high phase, closed at the falling edge
   always_ff @(negedge clk_sys or posedge rst) begin
      if (rst) begin
         latchQ_r <= 1'b0;
      end else begin
         latchQ_r <= extCountPin;
      end
   end

   always_comb begin
      state_nxt = state_r;
      state_nxt.syncQ = latchQ_r;
      state_nxt.prevQ = state_r.syncQ;
      state_nxt.rise = state_r.syncQ & ~state_r.prevQ;
      state_nxt.fall = ~state_r.syncQ & state_r.prevQ;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign riseTick = state_r.rise;
   assign fallTick = state_r.fall;
endmodule

// >>> verification/tpif_ext_clk_model.sv
// external count clock source driving every timer's count pin
// assumes run changes just after a rising system clock edge
`timescale 1ns/1ns
module tpif_ext_clk_model (
   // control
   input wire logic run,
   // count pins, one shared waveform
   output logic [tpif_pkg::NUM_TIMERS-1:0] extCountPin
);
   import tpif_pkg::*;
   logic slow;
   // halves of 43 and 45 ns walk the edges over both clock phases
   // pins hold their level while stopped
   initial begin
      extCountPin = '0;
      slow = 1'b0;
      forever begin
         wait (run === 1'b1);
         #(slow ? 45 : 43);
         if (run === 1'b1) begin
            extCountPin = ~extCountPin;
            slow = ~slow;
         end
      end
   end
endmodule

// >>> verification/testbench.sv
// self-checking bench for the shared prescaler and timer5 flag block
// assumes tpif_top as the design and the external clock model beside it
`timescale 1ns/1ns
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin miscompares++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module testbench;
   import tpif_pkg::*;
   typedef struct packed {
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic [7:0] exp;
      logic err;
   } tpif_row_s;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, gie, alt, run, cntOn, extOn, qe;
   logic [ADDR_W-1:0] paddr;
   logic [DATA_W-1:0] pwdata, prdata, q;
   logic [3:0] evt, ack, irqV;
   logic [WGM_W-1:0] wms;
   logic [CS_W-1:0] sel;
   logic [NUM_TIMERS-1:0] pin, tcc;
   int cnt [NUM_TIMERS];
   int nRise, nFall, nTests, miscompares, n;
   time lastEdge;
   int tapSh [NUM_TIMERS] = '{0, TAP8_W, TAP64_W, TAP256_W, TAP1024_W};
   tpif_row_s rows [14] = '{
      '{1'b0, ADDR_FLAGS, 8'h00, 8'h00, 1'b0}, '{1'b0, ADDR_MASK, 8'h00, 8'h00, 1'b0},
      '{1'b1, ADDR_MASK, 8'hFF, 8'h00, 1'b0}, '{1'b0, ADDR_MASK, 8'h00, 8'h2F, 1'b0},
      '{1'b1, ADDR_FLAGS, 8'hFF, 8'h00, 1'b0}, '{1'b0, ADDR_FLAGS, 8'h00, 8'h00, 1'b0},
      '{1'b1, ADDR_GCTRL, 8'hFF, 8'h00, 1'b0}, '{1'b0, ADDR_GCTRL, 8'h00, 8'h81, 1'b0},
      '{1'b1, ADDR_GCTRL, 8'h00, 8'h00, 1'b0}, '{1'b0, ADDR_GCTRL, 8'h00, 8'h00, 1'b0},
      '{1'b1, ADDR_GCTRL, 8'h01, 8'h00, 1'b0}, '{1'b0, ADDR_GCTRL, 8'h00, 8'h00, 1'b0},
      '{1'b1, 10'h004, 8'hFF, 8'h00, 1'b1}, '{1'b0, 10'h004, 8'h00, 8'h00, 1'b1}};

   tpif_top u_tpif_top (
      .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .extCountPin(pin), .timerCountClock(tcc), .counterWrap(evt[0]), .cmpMatchA(evt[1]),
      .cmpMatchB(evt[2]), .cmpMatchC(evt[3]), .altOverflowEvent(alt),
      .waveformModeSelect(wms), .globalIrqEnable(gie), .vecAckOverflow(ack[0]),
      .vecAckCmpA(ack[1]), .vecAckCmpB(ack[2]), .vecAckCmpC(ack[3]),
      .irqOverflow(irqV[0]), .irqCmpA(irqV[1]), .irqCmpB(irqV[2]), .irqCmpC(irqV[3]));

   tpif_ext_clk_model u_tpif_ext_clk_model (.run(run), .extCountPin(pin));

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(pin[0]) begin
      lastEdge = $time;
      if (cntOn) begin
         if (pin[0]) nRise++;
         else nFall++;
      end
   end

   // counts tick pulses; in pin mode each tick lands 2.5 to 3.5 clocks after its edge
   always @(posedge clk_sys) begin
      if (cntOn) foreach (cnt[i]) cnt[i] += tcc[i];
      if (extOn && tcc[0] === 1'b1) `CHK("edge delay", 1'b1, ($time - lastEdge) inside {[25:35]})
   end

   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         k++;
      end while (pready !== 1'b1 && k < 16);
      q = prdata;
      qe = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
      if (k >= 16) miscompares++;
   endtask

   task automatic pulse(input logic [3:0] e, input logic a);
      evt <= e;
      alt <= a;
      @(posedge clk_sys);
      evt <= 4'h0;
      alt <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic window(input int len, input logic r);
      cnt = '{default: 0};
      nRise = 0;
      nFall = 0;
      cntOn <= 1'b1;
      run <= r;
      repeat (len) @(posedge clk_sys);
      run <= 1'b0;
      repeat (r ? 10 : 0) @(posedge clk_sys);
      cntOn <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic note(input string s);
      $display("test %s done", s);
   endtask

   task automatic completeRun;
      $display("counts: %0d comparisons, %0d mismatches", nTests, miscompares);
      if (miscompares == 0 && nTests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      completeRun();
   end

   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      evt = 4'h0;
      ack = 4'h0;
      alt = 1'b0;
      gie = 1'b0;
      wms = WGM_NORMAL;
      run = 1'b0;
      cntOn = 1'b0;
      extOn = 1'b0;
      nTests = 0;
      miscompares = 0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      for (int i = 0; i < 14; i++) begin
         apb(rows[i].wr, rows[i].addr, DATA_W'(rows[i].wdata));
         if (!rows[i].wr) `CHK("register read", DATA_W'(rows[i].exp), q)
         `CHK("slave error", rows[i].err, qe)
      end
      note("registers");
      apb(1'b1, ADDR_CLKSEL, DATA_W'({CS_DIV1, 12'h000}));
      apb(1'b1, ADDR_MASK, 32'h0000000F);
      gie <= 1'b1;
      for (int i = 0; i < NUM_EVT; i++) begin
         pulse(4'h1 << i, 1'b0);
         apb(1'b0, ADDR_FLAGS, '0);
         `CHK("flag set", 8'h01 << i, q[7:0])
         `CHK("irq on", 4'h1 << i, irqV)
         gie <= 1'b0;
         @(posedge clk_sys);
         `CHK("irq gated", 4'h0, irqV)
         gie <= 1'b1;
         apb(1'b1, ADDR_FLAGS, '0);
         apb(1'b0, ADDR_FLAGS, '0);
         `CHK("flag kept", 8'h01 << i, q[7:0])
         if (i % 2 == 0) begin
            ack <= 4'h1 << i;
            @(posedge clk_sys);
            ack <= 4'h0;
            @(posedge clk_sys);
         end else apb(1'b1, ADDR_FLAGS, DATA_W'(8'h01 << i));
         apb(1'b0, ADDR_FLAGS, '0);
         `CHK("flag cleared", 8'h00, q[7:0])
      end
      note("flags");
      wms <= 4'h1;
      pulse(4'h1, 1'b0);
      apb(1'b0, ADDR_FLAGS, '0);
      `CHK("wrap ignored", 8'h00, q[7:0])
      pulse(4'h0, 1'b1);
      apb(1'b0, ADDR_FLAGS, '0);
      `CHK("alt overflow", 8'h01, q[7:0])
      apb(1'b1, ADDR_FLAGS, 32'h00000001);
      wms <= WGM_CTC_CMP;
      pulse(4'h1, 1'b0);
      apb(1'b0, ADDR_FLAGS, '0);
      `CHK("ctc overflow", 8'h01, q[7:0])
      note("overflow source");
      apb(1'b1, ADDR_CLKSEL, DATA_W'({CS_DIV1024, CS_DIV256, CS_DIV64, CS_DIV8, CS_DIV1}));
      window(2048, 1'b0);
      foreach (cnt[i]) `CHK("tap ticks", 2048 >> tapSh[i], cnt[i])
      apb(1'b1, ADDR_GCTRL, 32'h00000081);
      window(64, 1'b0);
      foreach (cnt[i]) `CHK("held taps", i == 0 ? 64 : 0, cnt[i])
      apb(1'b1, ADDR_GCTRL, '0);
      apb(1'b1, ADDR_CLKSEL, '0);
      window(64, 1'b0);
      foreach (cnt[i]) `CHK("stopped", 0, cnt[i])
      apb(1'b1, ADDR_CLKSEL, DATA_W'({CS_DIV8, CS_STOP}));
      n = 1;
      while (tcc[1] !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         n++;
      end
      `CHK("first tick", 1'b1, n <= 9)
      note("prescaler");
      extOn = 1'b1;
      for (int m = 0; m < 2; m++) begin
         sel = m ? CS_EXT_FALL : CS_EXT_RISE;
         apb(1'b1, ADDR_CLKSEL, DATA_W'({NUM_TIMERS{sel}}));
         window(400, 1'b1);
         foreach (cnt[i]) `CHK("edge ticks", m ? nFall : nRise, cnt[i])
      end
      extOn = 1'b0;
      note("external pin");
      pulse(4'h2, 1'b0);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      apb(1'b0, ADDR_FLAGS, '0);
      `CHK("flags after reset", 32'h0, q)
      apb(1'b0, ADDR_MASK, '0);
      `CHK("mask after reset", 32'h0, q)
      note("second reset");
      completeRun();
   end
endmodule
